// File: rtl/utd_map.vh
// Field positions, reset word and register offsets for the descriptor word-0 unit
`ifndef UTD_MAP_VH
`define UTD_MAP_VH
`define UTD_EP0_BIT        31
`define UTD_MULT_HI        30
`define UTD_MULT_LO        29
`define UTD_MPL_HI         28
`define UTD_MPL_LO         18
`define UTD_TBC_HI         17
`define UTD_TBC_LO         3
`define UTD_VALID_BIT      0
`define UTD_RL_HI          28
`define UTD_RL_LO          25
`define UTD_DONE_HI        14
`define UTD_DONE_LO        0
`define UTD_OFF_DW0        12'h000
`define UTD_OFF_DW2        12'h004
`define UTD_OFF_DW3        12'h008
`define UTD_OFF_CTRL       12'h00C
`define UTD_OFF_STAT       12'h010
`define UTD_RST_WORD       32'h00000000
`endif

// File: rtl/utd_word0.v
// Bulk descriptor word-0 decode, packet scheduler and isochronous byte count
// How it works
// - endpoint low bit is taken from descriptor bit 31
// - multiplier bits 30:29 give packets issued per descriptor execution
// - each packet is capped at max packet bytes from bits 28:18
// - byte count in bits 17:3 bounds total bytes moved
// - hardware clears valid when descriptor ends or fatal error occurs
// - isochronous bytes moved reported in fifteen-bit field of word three
// - zero reload makes the controller ignore the NAK retry count
module utd_word0 (
  input  wire        clock_i,
  input  wire        reset_i,
  input  wire        enable_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        pkt_done_i,
  input  wire [10:0] pkt_bytes_i,
  input  wire        nak_i,
  input  wire        fatal_i,
  output reg         pkt_start_o,
  output reg  [10:0] pkt_len_o,
  output reg         endpoint_number_o,
  output reg         busy_o
);
`include "utd_map.vh"
  localparam ST_IDLE = 2'b00;
  localparam ST_ISSUE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [31:0] word0;
  reg [31:0] word2;
  reg        iso_mode;
  reg [14:0] bytes_done_count;
  reg [14:0] remaining;
  reg [1:0]  pkts_left;
  reg [3:0]  nak_retry_count;
  reg        fatal_seen;
  reg [1:0]  state;
  reg [1:0]  next_state;
  reg [14:0] next_remaining;
  reg [31:0] next_rdata;
  reg        next_slverr;

  wire        access = psel_i & penable_i & pready_o;
  wire        wr = access & pwrite_i;
  // Setup cycle: read data and error are prepared for the access phase
  wire        setup = psel_i & ~pready_o;
  wire        hit_dw0 = (paddr_i == `UTD_OFF_DW0);
  wire        hit_dw2 = (paddr_i == `UTD_OFF_DW2);
  wire        hit_dw3 = (paddr_i == `UTD_OFF_DW3);
  wire        hit_ctrl = (paddr_i == `UTD_OFF_CTRL);
  wire        hit_stat = (paddr_i == `UTD_OFF_STAT);
  wire        hit_any = hit_dw0 | hit_dw2 | hit_dw3 | hit_ctrl | hit_stat;
  wire [10:0] max_packet_bytes = word0[`UTD_MPL_HI:`UTD_MPL_LO];
  wire [14:0] transfer_byte_count = word0[`UTD_TBC_HI:`UTD_TBC_LO];
  wire [3:0]  retry_reload = word2[`UTD_RL_HI:`UTD_RL_LO];
  wire [14:0] moved = {4'h0, pkt_bytes_i};
  wire        last_pkt = (moved >= remaining) || (pkts_left == 2'h1) || (pkt_bytes_i < max_packet_bytes);
  wire        nak_fatal = nak_i && (retry_reload != 4'h0) && (nak_retry_count == 4'h1);

  // byte count bounds transfer
  // The count is worked out ahead so a packet issued on the same edge sees the updated value
  always @*
  begin
    next_remaining = remaining;
    if (state == ST_IDLE)
      next_remaining = transfer_byte_count;
    else if (state == ST_WAIT && pkt_done_i)
    begin
      if (moved >= remaining)
        next_remaining = 15'h0000;
      else
        next_remaining = remaining - moved;
    end
  end

  wire [10:0] pkt_len = ({4'h0, max_packet_bytes} < next_remaining) ? max_packet_bytes : next_remaining[10:0];

  // Read data and error are registered, so they are chosen during setup
  always @*
  begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    if (setup)
    begin
      // Unmapped offsets answer with an error, and a write there is dropped
      next_slverr = ~hit_any;
      if (~pwrite_i)
      begin
        case (paddr_i)
          `UTD_OFF_DW0:  next_rdata = {word0[31:3], 2'b00, word0[0]};
          `UTD_OFF_DW2:  next_rdata = word2;
          `UTD_OFF_DW3:  next_rdata = {17'h00000, bytes_done_count};
          `UTD_OFF_CTRL: next_rdata = {31'h00000000, iso_mode};
          `UTD_OFF_STAT: next_rdata = {28'h0000000, fatal_seen, state, busy_o};
          default:       next_rdata = 32'h00000000;
        endcase
      end
    end
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (word0[`UTD_VALID_BIT] && transfer_byte_count != 15'h0000)
          next_state = ST_ISSUE;
      ST_ISSUE:
        // A fatal error ends the descriptor even before the packet is answered
        if (fatal_i)
          next_state = ST_IDLE;
        else
          next_state = ST_WAIT;
      ST_WAIT:
        if (fatal_i || nak_fatal || (pkt_done_i && last_pkt))
          next_state = ST_IDLE;
        else if (pkt_done_i || nak_i)
          next_state = ST_ISSUE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      word0 <= `UTD_RST_WORD;
      word2 <= `UTD_RST_WORD;
      iso_mode <= 1'b0;
      bytes_done_count <= 15'h0000;
      remaining <= 15'h0000;
      pkts_left <= 2'h0;
      nak_retry_count <= 4'h0;
      fatal_seen <= 1'b0;
      state <= ST_IDLE;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      pkt_start_o <= 1'b0;
      pkt_len_o <= 11'h000;
      endpoint_number_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else if (enable_i)
    begin
      state <= next_state;
      remaining <= next_remaining;
      pready_o <= psel_i & ~pready_o;
      pslverr_o <= next_slverr;
      prdata_o <= next_rdata;
      pkt_start_o <= (next_state == ST_ISSUE);
      busy_o <= (next_state != ST_IDLE);
      endpoint_number_o <= word0[`UTD_EP0_BIT];
      if (state == ST_IDLE && next_state == ST_ISSUE)
      begin
        pkts_left <= word0[`UTD_MULT_HI:`UTD_MULT_LO];
        bytes_done_count <= 15'h0000;
        nak_retry_count <= retry_reload;
        fatal_seen <= 1'b0;
      end
      if (next_state == ST_ISSUE)
        pkt_len_o <= pkt_len;
      if (state == ST_WAIT && pkt_done_i)
      begin
        pkts_left <= pkts_left - 2'h1;
        bytes_done_count <= bytes_done_count + moved;
      end
      if (state == ST_WAIT && nak_i && nak_retry_count != 4'h0)
        nak_retry_count <= nak_retry_count - 4'h1;
      if ((state == ST_ISSUE && fatal_i) || (state == ST_WAIT && (fatal_i || nak_fatal)))
        fatal_seen <= 1'b1;
      if (wr && hit_dw2)
        word2 <= pwdata_i;
      // Mode bit is only stored; the isochronous path is outside this unit
      if (wr && hit_ctrl)
        iso_mode <= pwdata_i[0];
      if (wr && hit_dw0)
        word0 <= pwdata_i;
      // hardware clears valid on completion or fatal error, winning over a same-cycle write
      if (state != ST_IDLE && next_state == ST_IDLE)
        word0[`UTD_VALID_BIT] <= 1'b0;
    end
  end
endmodule // utd_word0

// File: verif/tb_top.sv
// Self-checking bench for the descriptor word-0 unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, reset_i = 1, enable_i = 1, pkt_done_i = 0, nak_i = 0, fatal_i = 0;
  logic [10:0] pkt_bytes_i = 11'h000, pkt_len_o;
  logic [31:0] prdata_o, pwdata_i, q;
  logic [11:0] paddr_i;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, pkt_start_o, endpoint_number_o, busy_o;
  int num_errors = 0, cmp_count = 0;
  always #20 clock_i = ~clock_i;
  utd_word0 dut (.*);
  utd_host u_host (.clock_i, .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o), .psel_o(psel_i),
    .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Wait for a packet, check its length, answer with done, nak or fatal
  task automatic pk(input logic [2:0] ev, input logic [10:0] len);
    do @(posedge clock_i); while (pkt_start_o !== 1'b1);
    chk(pkt_len_o, len);
    {pkt_done_i, nak_i, fatal_i, pkt_bytes_i} <= {ev, len};
    @(posedge clock_i);
    {pkt_done_i, nak_i, fatal_i} <= 3'h0;
  endtask
  task automatic t_bulk();
    u_host.xfer(1'b1, 12'h000, 32'hC80012C1, q);
    pk(3'h4, 11'h200);
    pk(3'h4, 11'h058);
    u_host.xfer(1'b0, 12'h000, 32'h0, q);
    chk(q, 32'hC80012C0);
    chk(endpoint_number_o, 32'h1);
  endtask
  task automatic t_err();
    u_host.xfer(1'b1, 12'h004, 32'h0, q);
    u_host.xfer(1'b1, 12'h000, 32'h61000321, q);
    pk(3'h2, 11'h040);
    pk(3'h1, 11'h040);
    u_host.xfer(1'b0, 12'h000, 32'h0, q);
    chk(q, 32'h61000320);
    u_host.xfer(1'b0, 12'h008, 32'h0, q);
    chk(q[31:15], 32'h0);
    u_host.xfer(1'b0, 12'h020, 32'h0, q);
    chk(u_host.last_err, 32'h1);
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    t_bulk();
    t_err();
    stop_test();
  end
  // Whole run needs under a hundred cycles; the limit is 1000 cycles
  initial
  begin
    #40000;
    num_errors++;
    stop_test();
  end
endmodule // tb_top

// File: verif/utd_host.sv
// APB master model for descriptor-writing software
module utd_host (
  input  logic        clock_i, pready_i, pslverr_i,
  input  logic [31:0] prdata_i,
  output logic        psel_o = 0, penable_o = 0, pwrite_o = 0,
  output logic [11:0] paddr_o = 0,
  output logic [31:0] pwdata_o = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_err = 0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    {psel_o, pwrite_o, paddr_o, pwdata_o} <= {1'b1, w, a, d};
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i;
    last_err = pslverr_i;
    {psel_o, penable_o} <= 2'h0;
  endtask
endmodule // utd_host

// File: verif/utd_word0_checker.sv
// Port assertions for the descriptor word-0 unit
module utd_chk (
  input logic        clock_i, reset_i, psel_i, pwrite_i, pready_o, nak_i, fatal_i,
  input logic        pkt_start_o, endpoint_number_o, busy_o,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i, prdata_o,
  input logic [10:0] pkt_len_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire wr = psel_i & pready_o & pwrite_i;
  logic [31:0] w0;
  logic [3:0]  rl;
  logic [2:0]  n;
  // Software's copy: hardware valid clears never reach it
  always_ff @(posedge clock_i)
  begin
    w0 <= reset_i ? 32'h0 : wr && paddr_i == 12'h000 ? pwdata_i : w0;
    rl <= reset_i ? 4'h0 : wr && paddr_i == 12'h004 ? pwdata_i[28:25] : rl;
    n <= reset_i || wr && paddr_i == 12'h000 ? 3'h0 : n + {2'h0, pkt_start_o};
  end
  property p_ep; endpoint_number_o == $past(w0[31]); endproperty
  a_ep: assert property (p_ep) else $error("endpoint");
  property p_mul; pkt_start_o |-> n < {w0[30:29] == 2'h0, w0[30:29]}; endproperty
  a_mul: assert property (p_mul) else $error("mult");
  property p_mpl; pkt_start_o |-> pkt_len_o <= w0[28:18]; endproperty
  a_mpl: assert property (p_mpl) else $error("max len");
  property p_tbc; pkt_start_o |-> {4'h0, pkt_len_o} <= w0[17:3]; endproperty
  a_tbc: assert property (p_tbc) else $error("count");
  property p_fat; busy_o && fatal_i |=> !busy_o; endproperty
  a_fat: assert property (p_fat) else $error("fatal");
  property p_iso; psel_i && pready_o && !pwrite_i && paddr_i == 12'h008 |-> prdata_o[31:15] == 17'h0; endproperty
  a_iso: assert property (p_iso) else $error("done");
  property p_nak; busy_o && nak_i && rl == 4'h0 |=> busy_o && pkt_start_o; endproperty
  a_nak: assert property (p_nak) else $error("nak");
  property p_skp; $rose(busy_o) |-> w0[0]; endproperty
  a_skp: assert property (p_skp) else $error("skip");
endmodule // utd_chk
bind utd_word0 utd_chk u_chk (.*);
